/* core/cfn_pkg.sv */
// shared types and constants for the card file navigation block
// Notes on behaviour
// RULE1: Files are addressed and selected only by a two-byte identifier.
// RULE2: First id byte gives type: 3F root, 7F directory, 2F/6F leaf.
// RULE3: No two files under one parent may carry the same identifier.
// RULE4: No file may share its identifier with any ancestor.
// RULE5: Transparent leaf: byte offset plus count, offset 00 00 first byte.
// RULE6: Record files: equal-length records, numbered from 1, length in header.
// RULE7: Linear, pointer unset: next gives first record, previous gives last.
// RULE8: Linear, pointer set: current, next unless last, previous unless first.
// RULE9: Linear seek: from start, after pointer, from end, before pointer.
// RULE10: Aborted record action leaves the record pointer as it was.
// RULE11: At most 255 records of at most 255 bytes; eight-bit counters.
// RULE12: Cyclic: after record n comes 1, before record 1 comes n.
// RULE13: Cyclic: newest data in record 1, oldest in record n.
// RULE14: Cyclic updates use previous only; reads use any addressing.
// RULE15: Selecting a cyclic file points at the most recently written record.
// RULE16: After answer-to-reset the root is current directory, no leaf.
// RULE17: Selecting root or directory makes it current, clears current leaf.
// RULE18: Selecting a leaf makes it current; directory stays its parent.
// RULE19: Allowed: child, sibling directory, parent, current directory, root. Code refuses a parent that is neither the root nor a child of the root.
// RULE20: Reselecting the last selected file is always accepted.
// RULE21: Application command runs only if it belongs to current directory.
// RULE22: After selecting a linear file the record pointer is unset.
// RULE23: Refused or unknown selection leaves all navigation state unchanged.
package cfn_pkg;
   // identifier type bytes
   localparam logic [7:0]  TYPE_ROOT  = 8'h3F;
   localparam logic [7:0]  TYPE_DIR   = 8'h7F;
   localparam logic [7:0]  TYPE_LEAF_R = 8'h2F;
   localparam logic [7:0]  TYPE_LEAF_D = 8'h6F;
   localparam logic [15:0] ROOT_FID   = 16'h3F00;
   localparam logic [7:0]  REC_FIRST  = 8'h01;
   localparam logic [7:0]  REC_NONE   = 8'h00;
   // record addressing and seek modes
   localparam logic [1:0]  AM_ABS  = 2'h0;
   localparam logic [1:0]  AM_CUR  = 2'h1;
   localparam logic [1:0]  AM_NEXT = 2'h2;
   localparam logic [1:0]  AM_PREV = 2'h3;
   localparam logic [1:0]  SK_START = 2'h0;
   localparam logic [1:0]  SK_FWD   = 2'h1;
   localparam logic [1:0]  SK_END   = 2'h2;
   localparam logic [1:0]  SK_BWD   = 2'h3;

   typedef enum logic [3:0] {
      OP_SELECT = 4'h0, OP_READ_REC = 4'h1, OP_UPDATE_REC = 4'h2, OP_SEEK = 4'h3,
      OP_INCREASE = 4'h4, OP_READ_BIN = 4'h5, OP_UPDATE_BIN = 4'h6, OP_APP = 4'h7
   } cfn_op_t;
   typedef enum logic [1:0] {
      FK_DIR = 2'h0, FK_TRANS = 2'h1, FK_LINEAR = 2'h2, FK_CYCLIC = 2'h3
   } cfn_kind_t;
   typedef enum logic [2:0] {
      ST_OK = 3'h0, ST_NOT_FOUND = 3'h1, ST_NOT_ALLOWED = 3'h2, ST_NO_LEAF = 3'h3,
      ST_RANGE = 3'h4, ST_BAD_MODE = 3'h5, ST_ABORTED = 3'h6
   } cfn_status_t;

   typedef struct packed {
      cfn_op_t     op;
      logic [15:0] fid;
      logic [1:0]  mode;
      logic [7:0]  rec;
      logic [15:0] offset;
      logic [7:0]  count;
   } cfn_cmd_t;
   typedef struct packed {
      cfn_op_t     op;
      logic [15:0] fid;
      logic [7:0]  rec;
      logic        fwd;
      logic [15:0] offset;
      logic [7:0]  count;
   } cfn_st_req_t;
   typedef struct packed {
      logic        found;
      logic        dup;
      logic        abort;
      logic [15:0] parent;
      cfn_kind_t   kind;
      logic [7:0]  rec_cnt;
      logic [15:0] body_len;
      logic [7:0]  rec;
   } cfn_st_rsp_t;
   typedef struct packed {
      cfn_status_t status;
      logic [15:0] cur_dir;
      logic [15:0] cur_leaf;
      logic        leaf_valid;
      logic [7:0]  ptr;
      logic        ptr_set;
   } cfn_rsp_t;
endpackage

/* core/cfn_nav.sv */
// card file navigation: current directory, current leaf and record pointer
`timescale 1ns/10ps
module cfn_nav
(
   input  wire logic                 clock,
   input  wire logic                 arst_n,
   input  wire logic                 atr_done,
   input  wire logic                 cmd_valid,
   input  wire cfn_pkg::cfn_cmd_t    cmd,
   output logic                      cmd_ready,
   output logic                      rsp_valid,
   output cfn_pkg::cfn_rsp_t         rsp,
   output logic                      st_valid,
   output cfn_pkg::cfn_st_req_t      st_req,
   input  wire logic                 st_ack,
   input  wire cfn_pkg::cfn_st_rsp_t st_rsp
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE = 3'b001, S_LOOKUP = 3'b010, S_ACCESS = 3'b100
   } cfn_state_t;

   cfn_state_t           state_reg, state_next;
   cfn_pkg::cfn_cmd_t    cmd_reg;
   cfn_pkg::cfn_st_req_t st_req_reg;
   cfn_pkg::cfn_rsp_t    rsp_reg;
   logic                 rsp_valid_reg;
   logic [15:0]          cur_dir_reg, cur_parent_reg, cur_leaf_reg, last_sel_reg;
   logic                 leaf_valid_reg, ptr_set_reg;
   logic [7:0]           ptr_reg, rec_cnt_reg;
   logic [15:0]          body_len_reg;
   cfn_pkg::cfn_kind_t   leaf_kind_reg;

   // ------------------------------------------------------------
   // record resolution for a command arriving in idle
   // ------------------------------------------------------------
   wire take     = cmd_valid && (state_reg == S_IDLE);
   wire is_lin   = leaf_valid_reg && (leaf_kind_reg == cfn_pkg::FK_LINEAR);
   wire is_cyc   = leaf_valid_reg && (leaf_kind_reg == cfn_pkg::FK_CYCLIC);
   wire is_trans = leaf_valid_reg && (leaf_kind_reg == cfn_pkg::FK_TRANS);
   wire at_last  = ptr_reg == rec_cnt_reg;
   wire at_first = ptr_reg == cfn_pkg::REC_FIRST;
   // cyclic wraps, linear stops at the ends
   wire [7:0] nxt_rec = !ptr_set_reg ? cfn_pkg::REC_FIRST :                       // RULE7
                        at_last ? cfn_pkg::REC_FIRST : ptr_reg + 8'h01;           // RULE12
   wire [7:0] prv_rec = !ptr_set_reg ? rec_cnt_reg :                              // RULE7
                        at_first ? rec_cnt_reg : ptr_reg - 8'h01;                 // RULE12
   wire [7:0] abs_rec = cmd.rec;
   wire       abs_bad = (abs_rec == cfn_pkg::REC_NONE) || (abs_rec > rec_cnt_reg); // RULE6
   wire       cyc_ptr_bad = !ptr_set_reg && is_cyc;
   wire [7:0] tgt_rec = (cmd.mode == cfn_pkg::AM_ABS)  ? abs_rec :
                        (cmd.mode == cfn_pkg::AM_CUR)  ? ptr_reg :
                        (cmd.mode == cfn_pkg::AM_NEXT) ? nxt_rec : prv_rec;
   wire       rec_range_bad = (cmd.mode == cfn_pkg::AM_ABS) ? abs_bad :
                              (cmd.mode == cfn_pkg::AM_CUR) ? !ptr_set_reg :
                              (is_lin && ptr_set_reg && cmd.mode == cfn_pkg::AM_NEXT
                               && at_last) ||                                     // RULE8
                              (is_lin && ptr_set_reg && cmd.mode == cfn_pkg::AM_PREV
                               && at_first) || cyc_ptr_bad;                       // RULE8
   wire       upd_mode_bad = is_cyc && (cmd.mode != cfn_pkg::AM_PREV);            // RULE14
   // seek start record and direction
   wire       seek_fwd   = (cmd.mode == cfn_pkg::SK_START) || (cmd.mode == cfn_pkg::SK_FWD);
   wire [7:0] seek_start = (cmd.mode == cfn_pkg::SK_START) ? cfn_pkg::REC_FIRST :
                           (cmd.mode == cfn_pkg::SK_END)   ? rec_cnt_reg :
                           (cmd.mode == cfn_pkg::SK_FWD)   ? nxt_rec : prv_rec;   // RULE9
   wire       seek_bad   = ptr_set_reg && (((cmd.mode == cfn_pkg::SK_FWD) && at_last) ||
                           ((cmd.mode == cfn_pkg::SK_BWD) && at_first));          // RULE9
   wire [16:0] bin_end   = {1'b0, cmd.offset} + {9'h000, cmd.count};
   wire       bin_bad    = bin_end > {1'b0, body_len_reg};                        // RULE5

   // verdict on a command taken in idle
   logic        go_lookup, go_access;
   cfn_pkg::cfn_status_t idle_status;
   always_comb
   begin
      go_lookup   = 1'b0;
      go_access   = 1'b0;
      idle_status = cfn_pkg::ST_OK;
      case (cmd.op)
         cfn_pkg::OP_SELECT: go_lookup = 1'b1;                                    // RULE1
         cfn_pkg::OP_READ_REC, cfn_pkg::OP_UPDATE_REC:
            if (!(is_lin || is_cyc))
               idle_status = cfn_pkg::ST_NO_LEAF;
            else if (cmd.op == cfn_pkg::OP_UPDATE_REC && upd_mode_bad)
               idle_status = cfn_pkg::ST_BAD_MODE;                                // RULE14
            else if (rec_range_bad && !(cmd.op == cfn_pkg::OP_UPDATE_REC && is_cyc))
               idle_status = cfn_pkg::ST_RANGE;
            else
               go_access = 1'b1;
         cfn_pkg::OP_SEEK:
            if (!is_lin)
               idle_status = cfn_pkg::ST_NO_LEAF;
            else if (seek_bad)
               idle_status = cfn_pkg::ST_RANGE;                                   // RULE9
            else
               go_access = 1'b1;
         cfn_pkg::OP_INCREASE:
            if (!is_cyc)
               idle_status = cfn_pkg::ST_NO_LEAF;
            else
               go_access = 1'b1;
         cfn_pkg::OP_READ_BIN, cfn_pkg::OP_UPDATE_BIN:
            if (!is_trans)
               idle_status = cfn_pkg::ST_NO_LEAF;
            else if (bin_bad)
               idle_status = cfn_pkg::ST_RANGE;                                   // RULE5
            else
               go_access = 1'b1;
         cfn_pkg::OP_APP:
            if (cmd.fid != cur_dir_reg)
               idle_status = cfn_pkg::ST_NOT_ALLOWED;                             // RULE21
         default: idle_status = cfn_pkg::ST_BAD_MODE;
      endcase
   end

   // ------------------------------------------------------------
   // selection check on the store answer
   // ------------------------------------------------------------
   wire [15:0] sfid   = cmd_reg.fid;
   wire [7:0]  stype  = sfid[15:8];
   wire [15:0] spar   = st_rsp.parent;
   wire s_root  = sfid == cfn_pkg::ROOT_FID;
   wire s_dir   = (stype == cfn_pkg::TYPE_DIR) && (st_rsp.kind == cfn_pkg::FK_DIR);
   // leaf type byte must agree with the parent kind; a 7F id must be a directory
   wire type_ok = s_root || s_dir ||
                  ((stype == cfn_pkg::TYPE_LEAF_R) && (spar == cfn_pkg::ROOT_FID)) ||
                  ((stype == cfn_pkg::TYPE_LEAF_D) && (spar[15:8] == cfn_pkg::TYPE_DIR)); // RULE2
   wire unique_ok = !st_rsp.dup &&                                                 // RULE3
                    (s_root || (spar != sfid && sfid != cur_parent_reg)           // RULE4
                     || spar == cfn_pkg::ROOT_FID && sfid == cur_parent_reg);
   wire path_ok = (sfid == last_sel_reg) || s_root || (sfid == cur_dir_reg) ||     // RULE20
                  (spar == cur_dir_reg) || (sfid == cur_parent_reg) ||
                  (s_dir && cur_dir_reg != cfn_pkg::ROOT_FID && spar == cur_parent_reg); // RULE19
   wire sel_done   = (state_reg == S_LOOKUP) && st_ack;
   wire sel_ok     = st_rsp.found && type_ok && unique_ok && path_ok;
   wire sel_commit = sel_done && sel_ok;
   wire sel_is_dir = s_root || s_dir;
   wire acc_done   = (state_reg == S_ACCESS) && st_ack;
   wire acc_ok     = !st_rsp.abort && !(cmd_reg.op == cfn_pkg::OP_SEEK && !st_rsp.found);
   wire cyc_write  = (cmd_reg.op == cfn_pkg::OP_UPDATE_REC && leaf_kind_reg == cfn_pkg::FK_CYCLIC)
                     || cmd_reg.op == cfn_pkg::OP_INCREASE;

   // ------------------------------------------------------------
   // control flow
   // ------------------------------------------------------------
   always_comb
   begin
      case (state_reg)
         S_IDLE:   state_next = (take && go_lookup) ? S_LOOKUP :
                                (take && go_access) ? S_ACCESS : S_IDLE;
         S_LOOKUP: state_next = st_ack ? S_IDLE : S_LOOKUP;
         S_ACCESS: state_next = st_ack ? S_IDLE : S_ACCESS;
         default:  state_next = S_IDLE;
      endcase
   end

   assign cmd_ready = state_reg == S_IDLE;
   assign st_valid  = (state_reg == S_LOOKUP) || (state_reg == S_ACCESS);
   assign st_req    = st_req_reg;
   assign rsp_valid = rsp_valid_reg;
   assign rsp       = rsp_reg;

   // sequencing and store request capture
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg  <= S_IDLE;
         cmd_reg    <= '0;
         st_req_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         if (take)
         begin
            cmd_reg        <= cmd;
            st_req_reg.op  <= cmd.op;
            st_req_reg.fid <= (cmd.op == cfn_pkg::OP_SELECT) ? cmd.fid : cur_leaf_reg;
            st_req_reg.rec <= (cmd.op == cfn_pkg::OP_SEEK) ? seek_start : tgt_rec;
            st_req_reg.fwd <= seek_fwd;
            st_req_reg.offset <= cmd.offset;
            st_req_reg.count  <= cmd.count;
         end
      end
   end

   // navigation state; answer-to-reset restores the root
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cur_dir_reg    <= cfn_pkg::ROOT_FID;                                      // RULE16
         cur_parent_reg <= cfn_pkg::ROOT_FID;
         last_sel_reg   <= cfn_pkg::ROOT_FID;
         cur_leaf_reg   <= '0;
         leaf_valid_reg <= 1'b0;
         leaf_kind_reg  <= cfn_pkg::FK_DIR;
         ptr_reg        <= cfn_pkg::REC_NONE;
         ptr_set_reg    <= 1'b0;
         rec_cnt_reg    <= '0;
         body_len_reg   <= '0;
      end
      else if (atr_done)
      begin
         cur_dir_reg    <= cfn_pkg::ROOT_FID;                                      // RULE16
         cur_parent_reg <= cfn_pkg::ROOT_FID;
         last_sel_reg   <= cfn_pkg::ROOT_FID;
         leaf_valid_reg <= 1'b0;
         ptr_set_reg    <= 1'b0;
      end
      else if (sel_commit)
      begin
         last_sel_reg <= sfid;
         if (sel_is_dir)
         begin
            cur_dir_reg    <= sfid;                                                // RULE17
            cur_parent_reg <= s_root ? cfn_pkg::ROOT_FID : spar;
            leaf_valid_reg <= 1'b0;                                                // RULE17
            ptr_set_reg    <= 1'b0;
         end
         else
         begin
            cur_leaf_reg   <= sfid;                                                // RULE18
            leaf_valid_reg <= 1'b1;
            leaf_kind_reg  <= st_rsp.kind;
            rec_cnt_reg    <= st_rsp.rec_cnt;                                      // RULE11
            body_len_reg   <= st_rsp.body_len;
            ptr_set_reg    <= st_rsp.kind == cfn_pkg::FK_CYCLIC;                   // RULE22
            ptr_reg        <= cfn_pkg::REC_FIRST;                                  // RULE15
         end
      end
      else if (acc_done && acc_ok && (leaf_kind_reg != cfn_pkg::FK_TRANS))
      begin
         // newest record is always number one after a cyclic write
         ptr_set_reg <= 1'b1;
         ptr_reg     <= cyc_write ? cfn_pkg::REC_FIRST :                           // RULE13
                        (cmd_reg.op == cfn_pkg::OP_SEEK) ? st_rsp.rec : st_req_reg.rec; // RULE10
      end
   end

   // answer register, one pulse per command
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rsp_valid_reg <= 1'b0;
         rsp_reg       <= '0;
      end
      else
      begin
         rsp_valid_reg <= (take && !go_lookup && !go_access) || sel_done || acc_done;
         rsp_reg.status <= sel_done ? (!st_rsp.found ? cfn_pkg::ST_NOT_FOUND :
                                       sel_ok ? cfn_pkg::ST_OK : cfn_pkg::ST_NOT_ALLOWED) : // RULE23
                           acc_done ? (st_rsp.abort ? cfn_pkg::ST_ABORTED :
                                       acc_ok ? cfn_pkg::ST_OK : cfn_pkg::ST_NOT_FOUND) :
                           idle_status;
         rsp_reg.cur_dir    <= cur_dir_reg;
         rsp_reg.cur_leaf   <= cur_leaf_reg;
         rsp_reg.leaf_valid <= leaf_valid_reg;
         rsp_reg.ptr        <= ptr_reg;
         rsp_reg.ptr_set    <= ptr_set_reg;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   AST_ATR_ROOT: assert property (atr_done |=> cur_dir_reg == cfn_pkg::ROOT_FID && !leaf_valid_reg) // RULE16
      else $error("root not current after answer-to-reset");
   AST_DIR_SEL: assert property (sel_commit && sel_is_dir && !atr_done |=> // RULE17
      cur_dir_reg == $past(sfid) && !leaf_valid_reg) else $error("directory select wrong");
   AST_LEAF_SEL: assert property (sel_commit && !sel_is_dir && !atr_done |=> // RULE18
      cur_leaf_reg == $past(sfid) && leaf_valid_reg && $stable(cur_dir_reg))
      else $error("leaf select wrong");
   AST_REJECT_HOLD: assert property (sel_done && !sel_ok && !atr_done |=> // RULE23
      $stable(cur_dir_reg) && $stable(ptr_reg) && $stable(leaf_valid_reg) &&
      rsp.status != cfn_pkg::ST_OK) else $error("rejected select changed state");
   AST_RESELECT: assert property (sel_done && st_rsp.found && sfid == last_sel_reg // RULE20
      && !st_rsp.dup |=> rsp_valid && rsp.status == cfn_pkg::ST_OK)
      else $error("reselect refused");
   AST_LINEAR_UNSET: assert property (sel_commit && !atr_done // RULE22
      && st_rsp.kind == cfn_pkg::FK_LINEAR && !sel_is_dir |=> !ptr_set_reg)
      else $error("pointer set after linear select");
   AST_CYC_SELECT: assert property (sel_commit && !atr_done && !sel_is_dir // RULE15
      && st_rsp.kind == cfn_pkg::FK_CYCLIC |=> ptr_set_reg && ptr_reg == cfn_pkg::REC_FIRST)
      else $error("cyclic pointer not at newest");
   AST_ABORT_HOLD: assert property (acc_done && st_rsp.abort && !atr_done |=> // RULE10
      $stable(ptr_reg) && $stable(ptr_set_reg)) else $error("abort moved pointer");
   AST_NEXT_UNSET: assert property (take && is_lin && !ptr_set_reg // RULE7
      && cmd.op == cfn_pkg::OP_READ_REC && cmd.mode == cfn_pkg::AM_NEXT |=>
      st_req.rec == cfn_pkg::REC_FIRST && st_valid) else $error("next on unset pointer");
   AST_NEXT_LAST: assert property (take && is_lin && ptr_set_reg && at_last // RULE8
      && cmd.op == cfn_pkg::OP_READ_REC && cmd.mode == cfn_pkg::AM_NEXT |=>
      rsp_valid && rsp.status == cfn_pkg::ST_RANGE && !st_valid)
      else $error("next past last accepted");
   AST_CYC_WRAP: assert property (take && is_cyc && ptr_set_reg && at_last // RULE12
      && cmd.op == cfn_pkg::OP_READ_REC && cmd.mode == cfn_pkg::AM_NEXT |=>
      st_req.rec == cfn_pkg::REC_FIRST) else $error("cyclic wrap wrong");
   AST_CYC_UPD: assert property (take && is_cyc && cmd.op == cfn_pkg::OP_UPDATE_REC // RULE14
      && cmd.mode != cfn_pkg::AM_PREV |=> rsp_valid && rsp.status == cfn_pkg::ST_BAD_MODE)
      else $error("cyclic update mode accepted");
   AST_APP_DIR: assert property (take && cmd.op == cfn_pkg::OP_APP // RULE21
      && cmd.fid != cur_dir_reg |=> rsp_valid && rsp.status == cfn_pkg::ST_NOT_ALLOWED)
      else $error("foreign application command ran");
   AST_BIN_RANGE: assert property (take && is_trans && bin_bad // RULE5
      && cmd.op == cfn_pkg::OP_READ_BIN |=> !st_valid ##0 rsp.status == cfn_pkg::ST_RANGE)
      else $error("binary access past end");

   CVR_DIR_SEL:  cover property (sel_commit && sel_is_dir);
   CVR_CYC_READ: cover property (acc_done && acc_ok && leaf_kind_reg == cfn_pkg::FK_CYCLIC);
   CVR_SEEK_HIT: cover property (acc_done && cmd_reg.op == cfn_pkg::OP_SEEK && st_rsp.found);
   CVR_ABORT:    cover property (acc_done && st_rsp.abort);
endmodule

/* verification/cfn_store_model.sv */
// behavioural file store standing behind the navigation block
`timescale 1ns/10ps
module cfn_store_model
(
   input  wire logic                 clock,
   input  wire logic                 arst_n,
   input  wire logic                 st_valid,
   input  wire cfn_pkg::cfn_st_req_t st_req,
   input  wire logic [3:0]           delay,
   input  wire logic                 abort_on,
   output logic                      st_ack,
   output cfn_pkg::cfn_st_rsp_t      st_rsp
);
   logic [3:0]         wait_reg;
   logic               hit;
   logic [15:0]        par;
   logic [7:0]         n;
   logic [15:0]        blen;
   cfn_pkg::cfn_kind_t kind;
   // ------------------------------------------------------------
   // file table: ids unique, none equal to an ancestor
   // ------------------------------------------------------------
   assign hit  = st_req.fid inside {16'h3F00, 16'h7F10, 16'h7F20, 16'h2F01, 16'h6F3A, 16'h6F3B};
   assign par  = (st_req.fid[15:8] == 8'h6F) ? 16'h7F10 : 16'h3F00;
   assign kind = (st_req.fid == 16'h2F01) ? cfn_pkg::FK_TRANS :
                 (st_req.fid == 16'h6F3A) ? cfn_pkg::FK_LINEAR :
                 (st_req.fid == 16'h6F3B) ? cfn_pkg::FK_CYCLIC : cfn_pkg::FK_DIR;
   // record files hold four-byte records, counts fit in eight bits
   assign n    = (kind == cfn_pkg::FK_LINEAR) ? 8'h03 : (kind == cfn_pkg::FK_CYCLIC) ? 8'h02 : 8'h00;
   assign blen = (kind == cfn_pkg::FK_TRANS) ? 16'h0010 : {6'h00, n, 2'h0};
   // one answer per request after a settable wait; junk between answers
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_ack   <= 1'b0;
         wait_reg <= 4'h0;
         st_rsp   <= '0;
      end
      else if (st_valid && !st_ack && wait_reg == delay)
      begin
         st_ack   <= 1'b1;
         wait_reg <= 4'h0;
         st_rsp   <= '{hit, 1'b0, abort_on, par, kind, n, blen, st_req.rec};
      end
      else
      begin
         st_ack   <= 1'b0;
         wait_reg <= (st_valid && !st_ack) ? wait_reg + 4'h1 : 4'h0;
         st_rsp   <= ~st_rsp;
      end
   end
endmodule

/* verification/tb.sv */
// self-checking bench for the card file navigation block
`timescale 1ns/10ps
module tb;
   logic                 clock;
   logic                 arst_n;
   logic                 atr_done;
   logic                 cmd_valid;
   logic                 cmd_ready;
   logic                 rsp_valid;
   logic                 st_valid;
   logic                 st_ack;
   logic                 abort_on;
   logic [3:0]           delay;
   int                   errors;
   int                   tests_run;
   int                   cyc;
   cfn_pkg::cfn_cmd_t    cmd;
   cfn_pkg::cfn_rsp_t    rsp;
   cfn_pkg::cfn_rsp_t    r;
   cfn_pkg::cfn_st_req_t st_req;
   cfn_pkg::cfn_st_rsp_t st_rsp;

   cfn_nav uut (.clock(clock), .arst_n(arst_n), .atr_done(atr_done), .cmd_valid(cmd_valid),
      .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .st_valid(st_valid),
      .st_req(st_req), .st_ack(st_ack), .st_rsp(st_rsp));
   cfn_store_model store (.clock(clock), .arst_n(arst_n), .st_valid(st_valid), .st_req(st_req),
      .delay(delay), .abort_on(abort_on), .st_ack(st_ack), .st_rsp(st_rsp));

   // 40 MHz clock and cycle ceiling
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         errors++;
         final_report;
      end
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one command, wait for its answer, judge the status
   task automatic run(input cfn_pkg::cfn_op_t op, input logic [15:0] f, input logic [1:0] m,
                      input logic [7:0] rc, input cfn_pkg::cfn_status_t es);
      int n;
      @(posedge clock);
      #1 cmd_valid = 1'b1;
      cmd = '{op, f, m, rc, 16'h000A, rc};
      while (cmd_ready !== 1'b1) @(posedge clock) #1;
      @(posedge clock) #1 cmd_valid = 1'b0;
      for (n = 0; n < 40 && rsp_valid !== 1'b1; n++) @(posedge clock) #1;
      r = rsp;
      chk("status", {13'h0, r.status}, {13'h0, es});
   endtask

   task automatic t_atr;
      @(posedge clock) #1 atr_done = 1'b1;
      @(posedge clock) #1 atr_done = 1'b0;
      run(cfn_pkg::OP_APP, 16'h3F00, 2'h0, 8'h00, cfn_pkg::ST_OK);
      chk("dir", r.cur_dir, 16'h3F00);
      chk("leaf_valid", {15'h0, r.leaf_valid}, 16'h0000);
      $display("test atr done");
   endtask

   task automatic t_select;
      run(cfn_pkg::OP_SELECT, 16'h7F10, 2'h0, 8'h00, cfn_pkg::ST_OK);
      run(cfn_pkg::OP_SELECT, 16'h6F3A, 2'h0, 8'h00, cfn_pkg::ST_OK);
      chk("dir", r.cur_dir, 16'h7F10);
      chk("leaf_valid", {15'h0, r.leaf_valid}, 16'h0000);
      run(cfn_pkg::OP_SELECT, 16'h2F01, 2'h0, 8'h00, cfn_pkg::ST_NOT_ALLOWED);
      chk("leaf", r.cur_leaf, 16'h6F3A);
      run(cfn_pkg::OP_SELECT, 16'h7F99, 2'h0, 8'h00, cfn_pkg::ST_NOT_FOUND);
      chk("dir", r.cur_dir, 16'h7F10);
      run(cfn_pkg::OP_SELECT, 16'h6F3A, 2'h0, 8'h00, cfn_pkg::ST_OK);
      run(cfn_pkg::OP_SELECT, 16'h7F20, 2'h0, 8'h00, cfn_pkg::ST_OK);
      run(cfn_pkg::OP_APP, 16'h7F10, 2'h0, 8'h00, cfn_pkg::ST_NOT_ALLOWED);
      chk("dir", r.cur_dir, 16'h7F20);
      run(cfn_pkg::OP_SELECT, 16'h3F00, 2'h0, 8'h00, cfn_pkg::ST_OK);
      $display("test select done");
   endtask

   task automatic t_linear;
      delay = 4'h6;
      run(cfn_pkg::OP_SELECT, 16'h7F10, 2'h0, 8'h00, cfn_pkg::ST_OK);
      run(cfn_pkg::OP_SELECT, 16'h6F3A, 2'h0, 8'h00, cfn_pkg::ST_OK);
      run(cfn_pkg::OP_READ_REC, 16'h0, cfn_pkg::AM_PREV, 8'h00, cfn_pkg::ST_OK);
      chk("ptr_set", {15'h0, r.ptr_set}, 16'h0000);
      run(cfn_pkg::OP_READ_REC, 16'h0, cfn_pkg::AM_NEXT, 8'h00, cfn_pkg::ST_RANGE);
      chk("ptr", {8'h0, r.ptr}, 16'h0003);
      run(cfn_pkg::OP_SEEK, 16'h0, cfn_pkg::SK_FWD, 8'h00, cfn_pkg::ST_RANGE);
      abort_on = 1'b1;
      run(cfn_pkg::OP_READ_REC, 16'h0, cfn_pkg::AM_ABS, 8'h02, cfn_pkg::ST_ABORTED);
      abort_on = 1'b0;
      run(cfn_pkg::OP_SEEK, 16'h0, cfn_pkg::SK_START, 8'h00, cfn_pkg::ST_OK);
      chk("ptr", {8'h0, r.ptr}, 16'h0003);
      run(cfn_pkg::OP_READ_REC, 16'h0, cfn_pkg::AM_PREV, 8'h00, cfn_pkg::ST_RANGE);
      chk("ptr", {8'h0, r.ptr}, 16'h0001);
      run(cfn_pkg::OP_SELECT, 16'h6F3A, 2'h0, 8'h00, cfn_pkg::ST_OK);
      run(cfn_pkg::OP_READ_REC, 16'h0, cfn_pkg::AM_NEXT, 8'h00, cfn_pkg::ST_OK);
      run(cfn_pkg::OP_SEEK, 16'h0, cfn_pkg::SK_BWD, 8'h00, cfn_pkg::ST_RANGE);
      chk("ptr", {8'h0, r.ptr}, 16'h0001);
      delay = 4'h0;
      $display("test linear done");
   endtask

   task automatic t_cyclic;
      run(cfn_pkg::OP_SELECT, 16'h6F3B, 2'h0, 8'h00, cfn_pkg::ST_OK);
      run(cfn_pkg::OP_UPDATE_REC, 16'h0, cfn_pkg::AM_NEXT, 8'h00, cfn_pkg::ST_BAD_MODE);
      chk("ptr", {7'h0, r.ptr, r.ptr_set}, 16'h0003);
      run(cfn_pkg::OP_READ_REC, 16'h0, cfn_pkg::AM_NEXT, 8'h00, cfn_pkg::ST_OK);
      run(cfn_pkg::OP_READ_REC, 16'h0, cfn_pkg::AM_NEXT, 8'h00, cfn_pkg::ST_OK);
      chk("ptr", {8'h0, r.ptr}, 16'h0002);
      run(cfn_pkg::OP_UPDATE_REC, 16'h0, cfn_pkg::AM_PREV, 8'h00, cfn_pkg::ST_OK);
      chk("ptr", {8'h0, r.ptr}, 16'h0001);
      run(cfn_pkg::OP_READ_REC, 16'h0, cfn_pkg::AM_CUR, 8'h00, cfn_pkg::ST_OK);
      chk("ptr", {8'h0, r.ptr}, 16'h0001);
      run(cfn_pkg::OP_INCREASE, 16'h0, 2'h0, 8'h00, cfn_pkg::ST_OK);
      $display("test cyclic done");
   endtask

   task automatic t_trans;
      run(cfn_pkg::OP_SELECT, 16'h3F00, 2'h0, 8'h00, cfn_pkg::ST_OK);
      chk("ptr", {8'h0, r.ptr}, 16'h0001);
      run(cfn_pkg::OP_SELECT, 16'h2F01, 2'h0, 8'h00, cfn_pkg::ST_OK);
      run(cfn_pkg::OP_READ_BIN, 16'h0, 2'h0, 8'h06, cfn_pkg::ST_OK);
      run(cfn_pkg::OP_READ_BIN, 16'h0, 2'h0, 8'h07, cfn_pkg::ST_RANGE);
      run(cfn_pkg::OP_UPDATE_BIN, 16'h0, 2'h0, 8'h06, cfn_pkg::ST_OK);
      run(cfn_pkg::OP_READ_REC, 16'h0, cfn_pkg::AM_CUR, 8'h00, cfn_pkg::ST_NO_LEAF);
      $display("test transparent done");
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // reset, then the scenarios in turn
   initial
   begin
      {arst_n, atr_done, cmd_valid, abort_on, delay, cmd, errors, tests_run, cyc} = '0;
      repeat (5) @(posedge clock);
      #1 arst_n = 1'b1;
      t_atr;
      t_select;
      t_linear;
      t_cyclic;
      t_trans;
      t_atr;
      final_report;
   end
endmodule
